// file: logic/sbe_exec.sv
`timescale 1ns/1ns
`default_nettype none
module sbe_exec (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         insn_valid,
  input  wire logic [sbe_pkg::INSN_W-1:0]   insn,
  input  wire logic [sbe_pkg::DATA_W-1:0]   file_rdata,
  input  wire logic [sbe_pkg::DATA_W-1:0]   upper_address_latch,
  output logic      [sbe_pkg::FADR_W-1:0]   file_raddr,
  output sbe_pkg::sbe_fwr_t                 file_wr,
  output sbe_pkg::sbe_pcld_t                pc_ld,
  output logic      [sbe_pkg::DATA_W-1:0]   work_ff,
  output logic                              zero_ff,
  output logic                              squash_ff,
  output logic                              busy_ff
);
  import sbe_pkg::*;

  sbe_kind_t             kind;        // Decoded class of insn
  logic [5:0]            op6;         // Long opcode field
  logic [4:0]            op5;         // Literal-form opcode field
  logic [2:0]            op3;         // Branch opcode field
  logic [DATA_W-1:0]     result;      // ALU result
  logic [DATA_W-1:0]     opnd;        // File operand after the bypass
  logic                  dest_file;   // High sends result to file
  logic                  writes_zero; // Class updates the zero flag
  logic                  is_skip;     // Class skips on zero
  logic                  take;        // Instruction actually executes
  logic [FADR_W-1:0]     fadr;        // File operand address
  logic [PC_W-1:0]       nxt_target;  // Branch destination
  logic                  op_file;     // Class takes a file operand
  logic                  wr_file;     // Executed word writes a file register
  logic                  wr_work;     // Executed word writes the working register
  logic                  res_zero;    // ALU result is all zeros
  logic                  run_branch;  // Executed word is the branch
  logic                  run_skip;    // Executed skip that hit zero

  // Field split of the 14-bit word:
  //   [6:0] file address, [7] destination select
  //   [7:0] literal of the immediate OR
  //   [10:0] branch target
  assign op6        = insn[OP6_MSB:OP6_LSB];
  assign op5        = insn[OP5_MSB:OP5_LSB];
  assign op3        = insn[OP3_MSB:OP3_LSB];

  // Read address is combinational from the instruction
  // Left unregistered so the file answers within the same cycle
  assign fadr       = insn[FADR_W-1:0];
  assign dest_file  = insn[DEST_BIT];
  assign file_raddr = fadr;
  // Bypass: the write strobe lands one edge late, so a reader
  // of the same register right behind it takes the pending data
  assign opnd       = (file_wr.we && (file_wr.addr == fadr)) ? file_wr.data : file_rdata;
  // Skip and branch both work by dropping the next valid word
  // A squashed slot or the branch dead cycle executes nothing
  assign take       = insn_valid && !squash_ff && !busy_ff;

  // Classes whose result may go back to the file register
  assign op_file    = (kind == SBE_DEC_SKIP) || (kind == SBE_INC_SKIP) ||
                      (kind == SBE_INC_FILE) || (kind == SBE_OR_FILE);
  // Destination by d; the literal OR always lands in work
  assign wr_file    = take && op_file && dest_file;
  assign wr_work    = take && ((op_file && !dest_file) || (kind == SBE_OR_LIT));
  // One zero detect shared by the flag and the skip decision
  assign res_zero   = (result == '0);
  assign run_branch = take && (kind == SBE_BRANCH);
  assign run_skip   = take && is_skip && res_zero;

  // Decode the six handled opcodes
  // Long opcodes first; the short forms never alias them
  always_comb begin
    kind = SBE_NONE;
    if (op6 == OPC_DEC_SKIP) begin
      // Decrement, skip on zero
      kind = SBE_DEC_SKIP;
    end else if (op6 == OPC_INC_SKIP) begin
      // Increment, skip on zero
      kind = SBE_INC_SKIP;
    end else if (op6 == OPC_INC_FILE) begin
      // Plain increment
      kind = SBE_INC_FILE;
    end else if (op6 == OPC_OR_FILE) begin
      // OR of work with a file register
      kind = SBE_OR_FILE;
    end else if (op3 == OPC_BRANCH) begin
      // Unconditional branch, 11-bit target
      kind = SBE_BRANCH;
    end else if (op5 == OPC_OR_LIT) begin
      // OR of work with the literal
      kind = SBE_OR_LIT;
    end
    // Any other word stays none and does nothing
  end

  // ALU and per-class effects
  always_comb begin
    result      = '0;
    writes_zero = 1'b0;
    is_skip     = 1'b0;
    case (kind)
      SBE_DEC_SKIP: begin
        // Wraps 00 to FF; flags untouched
        result  = opnd - 8'h01;
        is_skip = 1'b1;
      end
      SBE_INC_SKIP: begin
        // Wraps FF to 00, which is what triggers the skip
        result  = opnd + 8'h01;
        is_skip = 1'b1;
      end
      SBE_INC_FILE: begin
        // Same adder as the skip form, but it owns the zero flag
        result      = opnd + 8'h01;
        writes_zero = 1'b1;
      end
      SBE_OR_FILE: begin
        // Work OR file register
        result      = work_ff | opnd;
        writes_zero = 1'b1;
      end
      SBE_OR_LIT: begin
        // Work OR the low byte of the word
        result      = work_ff | insn[DATA_W-1:0];
        writes_zero = 1'b1;
      end
      SBE_BRANCH: begin
        // Branch acts only through the pc load and the dead cycle
        result = '0;  // No data result
      end
      default: begin
        // Unknown words: no result, no effects
        result = '0;
      end
    endcase
  end

  // Target: latch bits 4:3 above the full 11-bit immediate, so 0..8191 all reachable
  assign nxt_target = {upper_address_latch[LATCH_HI:LATCH_LO], insn[TGT_W-1:0]};

  // Working register write-back
  // Refused words fall through and keep the old value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      work_ff <= WORK_RST;
    end else if (wr_work) begin
      // Literal OR, or a file class with d low
      work_ff <= result;
    end
  end

  // File register write-back, registered for clean outputs
  // One strobe per executed write; address and data ride along
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      file_wr <= '0;
    end else begin
      file_wr.we   <= wr_file;
      // Free running; only meaningful while the strobe is high
      file_wr.addr <= fadr;
      file_wr.data <= result;
    end
  end

  // Zero flag; skip variants and branch leave it alone
  // Skip forms share the adder but not the flag write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_ff <= 1'b0;
    end else if (take && writes_zero) begin
      // Set on an all-zero result, cleared otherwise
      zero_ff <= res_zero;
    end
  end

  // Skip: next fetched slot runs as a no-operation
  // Updated only on valid slots, so a fetch gap keeps it pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      squash_ff <= 1'b0;
    end else if (insn_valid) begin
      // A nonzero result clears it and the next word runs
      squash_ff <= run_skip;
    end
  end

  // Branch: load pc on the edge after the branch executes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_ld <= '0;
    end else begin
      pc_ld.load   <= run_branch;
      // Target follows insn; the fetch side looks only on load
      pc_ld.target <= nxt_target;
    end
  end

  // Branch dead cycle: the prefetched word after a branch is dropped
  // Cleared only by a valid slot, so fetch gaps do not lose it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (run_branch) begin
      busy_ff <= 1'b1;
    end else if (insn_valid) begin
      // The dead slot has now been consumed
      busy_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: logic/sbe_pkg.sv
`default_nettype none
package sbe_pkg;
  // Instruction word and datapath widths
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int FADR_W = 7;
  localparam int PC_W   = 13;
  localparam int TGT_W  = 11;

  // Opcode field positions
  localparam int OP6_MSB  = 13;
  localparam int OP6_LSB  = 8;
  localparam int DEST_BIT = 7;
  localparam int OP3_MSB  = 13;
  localparam int OP3_LSB  = 11;
  localparam int OP5_MSB  = 13;
  localparam int OP5_LSB  = 9;

  // Upper address latch bits feeding pc[12:11]
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;

  // Opcode encodings
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0] OPC_INC_FILE = 6'h0A;
  localparam logic [5:0] OPC_OR_FILE  = 6'h04;
  localparam logic [2:0] OPC_BRANCH   = 3'h5;
  localparam logic [4:0] OPC_OR_LIT   = 5'h1C;

  // Values after reset
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;

  // Instruction classes seen by the executor
  typedef enum logic [2:0] {
    SBE_NONE, SBE_DEC_SKIP, SBE_INC_SKIP, SBE_BRANCH,
    SBE_OR_LIT, SBE_INC_FILE, SBE_OR_FILE
  } sbe_kind_t;

  // File register write-back
  typedef struct packed {
    logic              we;
    logic [FADR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sbe_fwr_t;

  // Program counter load request
  typedef struct packed {
    logic            load;
    logic [PC_W-1:0] target;
  } sbe_pcld_t;
endpackage
`default_nettype wire

// file: tb/sbe_exec_chk.sv
`timescale 1ns/1ns
`default_nettype none
module sbe_exec_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        insn_valid,
  input wire logic        zero_ff,
  input wire logic        squash_ff,
  input wire logic        busy_ff,
  input wire logic [13:0] insn,
  input wire logic [13:0] pc_ld,
  input wire logic [15:0] file_wr,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  upper_address_latch,
  input wire logic [7:0]  work_ff
);
  import sbe_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Word executed this edge, opcode with d, write strobe and data
  wire t = insn_valid && !squash_ff && !busy_ff;
  wire [6:0] o = insn[13:7];
  wire we = file_wr[15];
  // Operand as the design sees it: a pending write to the same register wins
  wire [7:0] q = we && file_wr[14:8] == insn[6:0] ? file_wr[7:0] : file_rdata;
  wire [7:0] d = file_wr[7:0], l = work_ff | insn[7:0], f = work_ff | q;
  wire [13:0] g = {1'b1, upper_address_latch[4:3], insn[10:0]};
  property p_dec; t && o[6:1] == OPC_DEC_SKIP |=> squash_ff == ($past(q) == 8'h01) && $stable(zero_ff); endproperty
  a_dec: assert property (p_dec) else $error("dec");
  property p_wr; t && o == {OPC_DEC_SKIP, 1'b1} |=> we && d == $past(q) - 8'h01; endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_isk; t && o[6:1] == OPC_INC_SKIP |=> squash_ff == ($past(q) == 8'hFF) && $stable(zero_ff); endproperty
  a_isk: assert property (p_isk) else $error("isk");
  property p_br; t && o[6:4] == OPC_BRANCH |=> pc_ld == $past(g) && busy_ff && $stable(zero_ff); endproperty
  a_br: assert property (p_br) else $error("br");
  property p_orl; t && o[6:2] == OPC_OR_LIT |=> work_ff == $past(l) && zero_ff == !work_ff; endproperty
  a_orl: assert property (p_orl) else $error("orl");
  property p_inc; t && o == {OPC_INC_FILE, 1'b0} |=> work_ff == $past(q) + 8'h01 && zero_ff == !work_ff; endproperty
  a_inc: assert property (p_inc) else $error("inc");
  property p_orf; t && o == {OPC_OR_FILE, 1'b1} |=> we && d == $past(f) && zero_ff == !d; endproperty
  a_orf: assert property (p_orf) else $error("orf");
  property p_ref; insn_valid && !t |=> !we && !pc_ld[13] && $stable(work_ff); endproperty
  a_ref: assert property (p_ref) else $error("ref");
  c_sq: cover property (insn_valid && squash_ff);
  c_bz: cover property (insn_valid && busy_ff);
  c_z: cover property (we && zero_ff);
endmodule
bind sbe_exec sbe_exec_chk i_chk (
  .clk                 (clk),
  .rst_n               (rst_n),
  .insn_valid          (insn_valid),
  .zero_ff             (zero_ff),
  .squash_ff           (squash_ff),
  .busy_ff             (busy_ff),
  .insn                (insn),
  .pc_ld               (pc_ld),
  .file_wr             (file_wr),
  .file_rdata          (file_rdata),
  .upper_address_latch (upper_address_latch),
  .work_ff             (work_ff)
);
`default_nettype wire

// file: tb/sbe_file_model.sv
`timescale 1ns/1ns
`default_nettype none
// File registers: read at once, written on the edge
module sbe_file_model (
  input  wire logic              clk,
  input  wire logic [6:0]        file_raddr,
  input  wire sbe_pkg::sbe_fwr_t file_wr,
  output logic      [7:0]        file_rdata
);
  logic [7:0] mem [128]; // Preset by the bench
  assign file_rdata = mem[file_raddr];
  always @(posedge clk) if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("unexpected %0t value", $time); end end
module tb;
  import sbe_pkg::*;
  logic        clk = 0, rst_n = 0, insn_valid = 0, zero_ff, squash_ff, busy_ff;
  logic [13:0] insn = 0, x;
  logic [7:0]  upper_address_latch = 0, file_rdata, work_ff, r, e, ew;
  logic        ez = 1'b0; // Expected zero flag, clear after reset
  logic [6:0]  file_raddr;
  sbe_fwr_t    file_wr;
  sbe_pcld_t   pc_ld;
  integer      seed = 15435, mismatches = 0, n_compared = 0, i, k;
  logic [5:0]  ops [6] = '{OPC_DEC_SKIP, OPC_INC_SKIP, 6'h00, 6'h00, OPC_INC_FILE, OPC_OR_FILE};
  sbe_exec i_dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .insn_valid          (insn_valid),
    .insn                (insn),
    .file_rdata          (file_rdata),
    .upper_address_latch (upper_address_latch),
    .file_raddr          (file_raddr),
    .file_wr             (file_wr),
    .pc_ld               (pc_ld),
    .work_ff             (work_ff),
    .zero_ff             (zero_ff),
    .squash_ff           (squash_ff),
    .busy_ff             (busy_ff)
  );
  sbe_file_model i_mem (
    .clk        (clk),
    .file_raddr (file_raddr),
    .file_wr    (file_wr),
    .file_rdata (file_rdata)
  );
  initial forever #5 clk = ~clk;
  // Datapath result per class: 0 dec, 1 and 4 inc, 3 or literal, 5 or file
  function automatic logic [7:0] calc(integer k, logic [7:0] r, w, l);
    return k == 0 ? r - 8'h01 : k == 3 ? w | l : k == 5 ? w | r : r + 8'h01;
  endfunction
  task go(input logic [13:0] y);
    insn_valid = 1;
    insn = y;
    @(negedge clk);
    insn_valid = 0;
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: the loop needs about 240 cycles, this allows about eight times that
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
  initial begin
    for (k = 0; k < 128; k++) i_mem.mem[k] = 8'($random(seed));
    repeat (16) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    for (i = 0; i < 90; i++) begin
      k = i % 6;
      x = 14'($random(seed));
      upper_address_latch = 8'($random(seed));
      // Corners: targets 0 and 2047, operands that give a zero result
      if (i < 12 && k == 2) x[10:0] = i[1] ? 11'h7FF : 11'h000;
      if (i % 5 == 0) i_mem.mem[x[6:0]] = k ? 8'hFF : 8'h01;
      r = i_mem.mem[x[6:0]];
      e = calc(k, r, work_ff, x[7:0]);
      ew = k == 3 || k != 2 && !x[7] ? e : work_ff;
      // Classes 3, 4 and 5 own the zero flag; the rest leave it
      if (k >= 3) ez = e == 8'h00;
      go(k == 2 ? {OPC_BRANCH, x[10:0]} : k == 3 ? {OPC_OR_LIT, 1'b0, x[7:0]} : {ops[k], x[7:0]});
      `CHK(work_ff, ew)
      `CHK(zero_ff, ez)
      `CHK({squash_ff, busy_ff, pc_ld.load}, {k < 2 && e == 8'h00, k == 2, k == 2})
      if (k == 2) `CHK(pc_ld.target, {upper_address_latch[4:3], x[10:0]})
      @(negedge clk);
      if (k != 2 && k != 3 && x[7]) `CHK(i_mem.mem[x[6:0]], e)
      // A dead slot must swallow the following word whole
      if (k == 2 || k < 2 && e == 8'h00) begin
        go({OPC_OR_LIT, 9'h0FF});
        `CHK({squash_ff, busy_ff, zero_ff, work_ff}, {2'b00, ez, ew})
        // Let an edge pass before the next word raises valid again
        @(negedge clk);
      end
      $display("test %0d done", i);
    end
    final_report;
  end
endmodule
`default_nettype wire
